// >>> src/aux_bit_sync.sv
// Two-flop level synchroniser, one chain per bit
`timescale 1ns/10ps
module aux_bit_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				meta_reg[i] <= 1'b0;
				q_o[i] <= 1'b0;
			end else begin
				meta_reg[i] <= d_i[i];
				q_o[i] <= meta_reg[i];
			end
		end
	end
endmodule

// >>> src/aux_burst_timer.sv
// Data-mode period counter placing trigger and fetch events
`timescale 1ns/10ps
`include "aux_i2c_cfg.svh"
module aux_burst_timer #(
	parameter logic [31:0] PERIOD_CYC = `AUX_PERIOD_CYC,
	parameter logic [31:0] STEP_CYC = `AUX_OFFSET_STEP_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [3:0] offset_i,
	aux_sched_if.src ev
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic [31:0] trig_at;
	logic trig_reg;
	logic fetch_reg;

	// Offset zero triggers just after the update, otherwise N steps before it
	assign trig_at = (offset_i == 4'h0) ? 32'h1 : PERIOD_CYC - {28'h0, offset_i} * STEP_CYC;
	assign cnt_next = (cnt_reg == PERIOD_CYC - 32'h1) ? 32'h0 : cnt_reg + 32'h1;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_reg <= 32'h0;
			trig_reg <= 1'b0;
			fetch_reg <= 1'b0;
		end else begin
			cnt_reg <= run_i ? cnt_next : 32'h0;
			trig_reg <= run_i & (cnt_reg == trig_at);
			fetch_reg <= run_i & (cnt_reg == PERIOD_CYC - 32'h1);
		end
	end

	assign ev.trig = trig_reg;
	assign ev.fetch = fetch_reg;
endmodule

// >>> src/aux_i2c_cfg.svh
// Constants for the auxiliary sensor I2C master
`ifndef AUX_I2C_CFG_SVH
`define AUX_I2C_CFG_SVH

`define AUX_CLK_KHZ 200000
`define AUX_LINK_KHZ 66667
`define AUX_SCL_KHZ 400
`define AUX_SCL_QTR_CYC ((`AUX_LINK_KHZ + 4 * `AUX_SCL_KHZ - 1) / (4 * `AUX_SCL_KHZ))
`define AUX_OFFSET_STEP_US 2500
`define AUX_OFFSET_STEP_CYC (`AUX_OFFSET_STEP_US * (`AUX_CLK_KHZ / 1000))
`define AUX_PERIOD_US 40000
`define AUX_PERIOD_CYC (`AUX_PERIOD_US * (`AUX_CLK_KHZ / 1000))
`define AUX_BURST_LEN_0 4'h1
`define AUX_BURST_LEN_1 4'h2
`define AUX_BURST_LEN_2 4'h6
`define AUX_BURST_LEN_3 4'h8
`define AUX_RW_WRITE 1'b0
`define AUX_RW_READ 1'b1

`endif

// >>> src/aux_i2c_pkg.sv
// Types for the auxiliary sensor I2C master
package aux_i2c_pkg;

	typedef enum logic [4:0] {
		LK_IDLE = 5'h01,
		LK_START = 5'h02,
		LK_TX = 5'h04,
		LK_RX = 5'h08,
		LK_STOP = 5'h10
	} link_state_type;

	typedef enum logic [3:0] {
		XK_MAN_RD = 4'h1,
		XK_MAN_WR = 4'h2,
		XK_FETCH = 4'h4,
		XK_TRIG = 4'h8
	} xfer_kind_type;

endpackage

// >>> src/aux_sched_if.sv
// Schedule events from the burst timer to the master
`timescale 1ns/10ps
interface aux_sched_if;
	logic trig;
	logic fetch;
	modport src (output trig, output fetch);
	modport dst (input trig, input fetch);
endinterface

// >>> src/aux_sensor_i2c_master.sv
// Auxiliary sensor I2C master: setup and data modes, link-side engine
`timescale 1ns/10ps
`include "aux_i2c_cfg.svh"
module aux_sensor_i2c_master #(
	parameter logic [31:0] PERIOD_CYC = `AUX_PERIOD_CYC,
	parameter logic [31:0] STEP_CYC = `AUX_OFFSET_STEP_CYC
) (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	// Configuration
	input wire logic if_mode_i,
	input wire logic manual_en_i,
	input wire logic adv_power_save_i,
	input wire logic aux_en_i,
	input wire logic [6:0] dev_addr_i,
	input wire logic [1:0] rd_burst_i,
	input wire logic [3:0] aux_offset_i,
	// Host register writes and data reads
	input wire logic rd_addr_we_i,
	input wire logic wr_addr_we_i,
	input wire logic wr_data_we_i,
	input wire logic [7:0] wdata_i,
	input wire logic data_rd_i,
	// Status and data
	output logic indirect_op_busy_o,
	output logic drdy_o,
	output logic nack_o,
	output logic [63:0] data_o,
	// FIFO stream
	output logic fifo_valid_o,
	output logic [3:0] fifo_len_o,
	output logic [63:0] fifo_data_o,
	// Auxiliary bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	////////////////////////////////////////////////////////////////////////
	// Mode decode and host-written registers
	logic setup_mode;
	logic data_mode;
	logic [3:0] burst_len;
	logic [7:0] rd_addr_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;

	assign setup_mode = if_mode_i & manual_en_i & ~adv_power_save_i & ~aux_en_i;
	assign data_mode = if_mode_i & ~manual_en_i & aux_en_i;
	assign burst_len = (rd_burst_i == 2'h3) ? `AUX_BURST_LEN_3 :
		(rd_burst_i == 2'h2) ? `AUX_BURST_LEN_2 :
		(rd_burst_i == 2'h1) ? `AUX_BURST_LEN_1 : `AUX_BURST_LEN_0;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_addr_reg <= 8'h00;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			if (rd_addr_we_i) rd_addr_reg <= wdata_i;
			if (wr_addr_we_i) wr_addr_reg <= wdata_i;
			if (wr_data_we_i) wr_data_reg <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data-mode schedule
	aux_sched_if sched ();

	aux_burst_timer #(
		.PERIOD_CYC(PERIOD_CYC),
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(data_mode),
		.offset_i(aux_offset_i),
		.ev(sched.src)
	);

	////////////////////////////////////////////////////////////////////////
	// Request arbitration and handshake, system side
	logic man_rd_pend_reg;
	logic man_wr_pend_reg;
	logic fetch_pend_reg;
	logic trig_pend_reg;
	logic out_reg;
	logic req_tgl_reg;
	logic ack_s;
	logic ack_seen_reg;
	logic ack_edge;
	logic pick_mrd;
	logic pick_mwr;
	logic pick_fetch;
	logic pick_trig;
	logic issue;
	aux_i2c_pkg::xfer_kind_type x_kind_reg;
	logic x_read_reg;
	logic [7:0] x_addr_reg;
	logic [3:0] x_len_reg;
	logic busy_reg;
	logic drdy_reg;
	logic nack_reg;
	logic [63:0] data_reg;
	logic fifo_valid_reg;
	logic [3:0] fifo_len_reg;
	logic [63:0] fifo_data_reg;
	logic [63:0] rd_buf_reg;
	logic lk_nack_reg;
	logic ack_tgl_reg;

	assign ack_edge = ack_s ^ ack_seen_reg;
	// Manual work wins; in data mode the trigger goes before a colliding fetch
	assign pick_mrd = ~out_reg & man_rd_pend_reg;
	assign pick_mwr = ~out_reg & ~man_rd_pend_reg & man_wr_pend_reg;
	assign pick_trig = ~out_reg & ~man_rd_pend_reg & ~man_wr_pend_reg & trig_pend_reg;
	assign pick_fetch = ~out_reg & ~man_rd_pend_reg & ~man_wr_pend_reg & ~trig_pend_reg
		& fetch_pend_reg;
	assign issue = pick_mrd | pick_mwr | pick_fetch | pick_trig;

	aux_bit_sync #(.W(1)) u_ack_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.d_i(ack_tgl_reg),
		.q_o(ack_s)
	);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			man_rd_pend_reg <= 1'b0;
			man_wr_pend_reg <= 1'b0;
			fetch_pend_reg <= 1'b0;
			trig_pend_reg <= 1'b0;
		end else begin
			man_rd_pend_reg <= (man_rd_pend_reg & ~pick_mrd) | (rd_addr_we_i & setup_mode);
			man_wr_pend_reg <= (man_wr_pend_reg & ~pick_mwr) | (wr_addr_we_i & setup_mode);
			// Leaving data mode drops queued work so nothing stale is collected
			fetch_pend_reg <= data_mode & ((fetch_pend_reg & ~pick_fetch) | sched.fetch);
			trig_pend_reg <= data_mode & ((trig_pend_reg & ~pick_trig) | sched.trig);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			x_kind_reg <= aux_i2c_pkg::XK_MAN_RD;
			x_read_reg <= 1'b0;
			x_addr_reg <= 8'h00;
			x_len_reg <= 4'h1;
		end else begin
			ack_seen_reg <= ack_s;
			if (issue) begin
				out_reg <= 1'b1;
				req_tgl_reg <= ~req_tgl_reg;
				x_read_reg <= pick_mrd | pick_fetch;
				x_addr_reg <= (pick_mrd | pick_fetch) ? rd_addr_reg : wr_addr_reg;
				x_len_reg <= burst_len;
				x_kind_reg <= pick_mrd ? aux_i2c_pkg::XK_MAN_RD :
					pick_mwr ? aux_i2c_pkg::XK_MAN_WR :
					pick_fetch ? aux_i2c_pkg::XK_FETCH : aux_i2c_pkg::XK_TRIG;
			end else if (ack_edge) begin
				out_reg <= 1'b0;
			end
		end
	end

	// Completion: link buffer is stable after its acknowledge toggles
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_reg <= 1'b0;
			drdy_reg <= 1'b0;
			nack_reg <= 1'b0;
			data_reg <= 64'h0;
			fifo_valid_reg <= 1'b0;
			fifo_len_reg <= 4'h0;
			fifo_data_reg <= 64'h0;
		end else begin
			busy_reg <= (rd_addr_we_i | wr_addr_we_i) & setup_mode |
				(busy_reg & ~(ack_edge & ~x_kind_reg[2] & ~x_kind_reg[3]));
			fifo_valid_reg <= ack_edge & x_kind_reg[2];
			drdy_reg <= (ack_edge & x_kind_reg[2]) | (drdy_reg & ~data_rd_i);
			if (ack_edge) nack_reg <= lk_nack_reg;
			if (ack_edge & x_read_reg) data_reg <= rd_buf_reg;
			if (ack_edge & x_kind_reg[2]) begin
				fifo_data_reg <= rd_buf_reg;
				fifo_len_reg <= x_len_reg;
			end
		end
	end

	assign indirect_op_busy_o = busy_reg;
	assign drdy_o = drdy_reg;
	assign nack_o = nack_reg;
	assign data_o = data_reg;
	assign fifo_valid_o = fifo_valid_reg;
	assign fifo_len_o = fifo_len_reg;
	assign fifo_data_o = fifo_data_reg;

	////////////////////////////////////////////////////////////////////////
	// Link-side I2C engine on link_clk_i
	aux_i2c_pkg::link_state_type st_reg;
	logic [2:0] lk_in_s;
	logic req_s;
	logic scl_s;
	logic sda_s;
	logic req_seen_reg;
	logic [7:0] qcnt_reg;
	logic [1:0] qph_reg;
	logic [3:0] bit_reg;
	logic [1:0] idx_reg;
	logic [3:0] rx_cnt_reg;
	logic [7:0] sh_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic tick;
	logic bit_ack;
	logic rx_last;
	logic [7:0] tx_byte;

	aux_bit_sync #(.W(3)) u_link_sync (
		.clk_i(link_clk_i),
		.resetn_i(resetn_i),
		.d_i({req_tgl_reg, scl_i, sda_i}),
		.q_o(lk_in_s)
	);
	assign req_s = lk_in_s[2];
	assign scl_s = lk_in_s[1];
	assign sda_s = lk_in_s[0];

	// Quarter-bit tick; the quarter after SCL release waits while the sensor stretches it
	assign tick = (qcnt_reg == 8'(`AUX_SCL_QTR_CYC - 1)) & ~((qph_reg == 2'h2) & ~scl_s);
	assign bit_ack = (bit_reg == 4'h8);
	assign rx_last = (rx_cnt_reg == x_len_reg - 4'h1);
	assign tx_byte = (idx_reg == 2'h0) ? {dev_addr_i, `AUX_RW_WRITE} :
		(idx_reg == 2'h1) ? x_addr_reg :
		x_read_reg ? {dev_addr_i, `AUX_RW_READ} : wr_data_reg;

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qcnt_reg <= 8'h00;
			qph_reg <= 2'h0;
		end else if (st_reg == aux_i2c_pkg::LK_IDLE) begin
			qcnt_reg <= 8'h00;
			qph_reg <= 2'h0;
		end else if (tick) begin
			qcnt_reg <= 8'h00;
			qph_reg <= qph_reg + 2'h1;
		end else if (qcnt_reg != 8'(`AUX_SCL_QTR_CYC - 1)) begin
			qcnt_reg <= qcnt_reg + 8'h01;
		end
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= aux_i2c_pkg::LK_IDLE;
			req_seen_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			bit_reg <= 4'h0;
			idx_reg <= 2'h0;
			rx_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			lk_nack_reg <= 1'b0;
			rd_buf_reg <= 64'h0;
		end else begin
			case (st_reg)
				aux_i2c_pkg::LK_IDLE: begin
					if (req_s != req_seen_reg) begin
						req_seen_reg <= req_s;
						idx_reg <= 2'h0;
						rx_cnt_reg <= 4'h0;
						lk_nack_reg <= 1'b0;
						st_reg <= aux_i2c_pkg::LK_START;
					end
				end
				// Start and repeated start share one sequence
				aux_i2c_pkg::LK_START: begin
					if (tick) begin
						case (qph_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							default: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= 4'h0;
								st_reg <= aux_i2c_pkg::LK_TX;
							end
						endcase
					end
				end
				aux_i2c_pkg::LK_TX: begin
					if (tick) begin
						case (qph_reg)
							2'h0: sda_oe_reg <= ~bit_ack & ~tx_byte[~bit_reg[2:0]];
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: if (bit_ack) lk_nack_reg <= sda_s;
							default: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= bit_ack ? 4'h0 : bit_reg + 4'h1;
								if (bit_ack) begin
									if (lk_nack_reg) begin
										st_reg <= aux_i2c_pkg::LK_STOP;
									end else if (idx_reg == 2'h2) begin
										st_reg <= x_read_reg ? aux_i2c_pkg::LK_RX
											: aux_i2c_pkg::LK_STOP;
									end else begin
										idx_reg <= idx_reg + 2'h1;
										if (idx_reg == 2'h1 && x_read_reg) begin
											st_reg <= aux_i2c_pkg::LK_START;
										end
									end
								end
							end
						endcase
					end
				end
				aux_i2c_pkg::LK_RX: begin
					if (tick) begin
						case (qph_reg)
							2'h0: sda_oe_reg <= bit_ack & ~rx_last;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: if (!bit_ack) sh_reg <= {sh_reg[6:0], sda_s};
							default: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= bit_ack ? 4'h0 : bit_reg + 4'h1;
								if (bit_ack) begin
									rd_buf_reg[{rx_cnt_reg[2:0], 3'h0} +: 8] <= sh_reg;
									rx_cnt_reg <= rx_cnt_reg + 4'h1;
									if (rx_last) st_reg <= aux_i2c_pkg::LK_STOP;
								end
							end
						endcase
					end
				end
				aux_i2c_pkg::LK_STOP: begin
					if (tick) begin
						case (qph_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							default: begin
								ack_tgl_reg <= ~ack_tgl_reg;
								st_reg <= aux_i2c_pkg::LK_IDLE;
							end
						endcase
					end
				end
				default: st_reg <= aux_i2c_pkg::LK_IDLE;
			endcase
		end
	end

	// Open drain: the line is only ever pulled low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_reg;
	assign sda_oe_o = sda_oe_reg;
endmodule

// >>> verif/aux_sensor_i2c_master_assertions.sv
// Port-level checks for the auxiliary sensor I2C master
`timescale 1ns/10ps
`include "aux_i2c_cfg.svh"
module aux_sensor_i2c_master_assertions #(
	parameter logic [31:0] PERIOD_CYC = `AUX_PERIOD_CYC,
	parameter logic [31:0] STEP_CYC = `AUX_OFFSET_STEP_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Configuration and strobes
	input wire logic if_mode_i,
	input wire logic manual_en_i,
	input wire logic adv_power_save_i,
	input wire logic aux_en_i,
	input wire logic [1:0] rd_burst_i,
	input wire logic rd_addr_we_i,
	input wire logic wr_addr_we_i,
	input wire logic data_rd_i,
	// Outputs watched
	input wire logic indirect_op_busy_o,
	input wire logic drdy_o,
	input wire logic [63:0] data_o,
	input wire logic fifo_valid_o,
	input wire logic [3:0] fifo_len_o,
	input wire logic scl_oe_o
);
	logic setup_mode, start_req, scl_q;
	logic [9:0] period_cnt, low_cnt;
	logic [16:0] busy_cnt;
	logic [3:0] exp_len;
	assign setup_mode = if_mode_i && manual_en_i && !adv_power_save_i && !aux_en_i;
	assign start_req = rd_addr_we_i || wr_addr_we_i;
	assign exp_len = rd_burst_i == 2'h3 ? `AUX_BURST_LEN_3 : rd_burst_i == 2'h2 ? `AUX_BURST_LEN_2
		: rd_burst_i == 2'h1 ? `AUX_BURST_LEN_1 : `AUX_BURST_LEN_0;
	////////////////////////////////////////////////////////////////////////////////
	// Period and low counters saturate so idle gaps never wrap into a false short period
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_q <= 1'b0;
			period_cnt <= 10'h3FF;
			low_cnt <= 10'h000;
			busy_cnt <= 17'h00000;
		end else begin
			scl_q <= scl_oe_o;
			period_cnt <= (scl_oe_o && !scl_q) ? 10'h001
				: period_cnt + {9'h000, period_cnt != 10'h3FF};
			low_cnt <= scl_oe_o ? low_cnt + {9'h000, low_cnt != 10'h3FF} : 10'h000;
			busy_cnt <= indirect_op_busy_o ? busy_cnt + 17'h00001 : 17'h00000;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence setup_strobe;
		start_req && setup_mode && !indirect_op_busy_o;
	endsequence
	sequence host_clear;
		drdy_o && data_rd_i ##1 !fifo_valid_o;
	endsequence
	busy_start_a: assert property (setup_strobe |=> indirect_op_busy_o)
		else $error("busy missing after setup strobe");
	no_start_a: assert property (
		start_req && !setup_mode && !indirect_op_busy_o |=> !indirect_op_busy_o)
		else $error("transfer started outside setup mode");
	busy_bound_a: assert property (busy_cnt < 17'h186A0)
		else $error("busy never cleared");
	scl_period_a: assert property ($rose(scl_oe_o) |-> period_cnt >= 10'h1EF)
		else $error("clock period too short");
	scl_low_a: assert property ($fell(scl_oe_o) |-> low_cnt >= 10'h06E)
		else $error("clock low phase too short");
	data_cause_a: assert property (
		!$stable(data_o) |-> $fell(indirect_op_busy_o) || fifo_valid_o)
		else $error("data changed without a completed read");
	store_ready_a: assert property (fifo_valid_o |-> drdy_o && fifo_len_o == exp_len)
		else $error("stored burst without ready or with wrong length");
	ready_clear_a: assert property (host_clear |-> !drdy_o)
		else $error("ready not cleared by data read");
	ready_hold_a: assert property (drdy_o && !data_rd_i |=> drdy_o)
		else $error("ready dropped without data read");
	ready_cause_a: assert property ($rose(drdy_o) |-> fifo_valid_o)
		else $error("ready rose without stored data");
endmodule

bind aux_sensor_i2c_master aux_sensor_i2c_master_assertions #(
	.PERIOD_CYC(PERIOD_CYC),
	.STEP_CYC(STEP_CYC)
) u_aux_sensor_i2c_master_assertions (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.if_mode_i(if_mode_i),
	.manual_en_i(manual_en_i),
	.adv_power_save_i(adv_power_save_i),
	.aux_en_i(aux_en_i),
	.rd_burst_i(rd_burst_i),
	.rd_addr_we_i(rd_addr_we_i),
	.wr_addr_we_i(wr_addr_we_i),
	.data_rd_i(data_rd_i),
	.indirect_op_busy_o(indirect_op_busy_o),
	.drdy_o(drdy_o),
	.data_o(data_o),
	.fifo_valid_o(fifo_valid_o),
	.fifo_len_o(fifo_len_o),
	.scl_oe_o(scl_oe_o)
);

// >>> verif/aux_sensor_i2c_master_bench.sv
// Self-checking bench for the auxiliary sensor I2C master
`timescale 1ns/10ps
`include "aux_i2c_cfg.svh"
`define CHECK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("FAIL %0t %s", $time, msg); end end
module aux_sensor_i2c_master_bench;
	// Rows: if_mode, manual, power save, enable, then transfer expected
	localparam logic [4:0] ROWS [4] = '{5'h1C, 5'h08, 5'h1A, 5'h19};
	localparam logic [6:0] SENSOR_ADDR = 7'h12;
	logic clk_i = 1'b0, link_clk_i = 1'b0, resetn_i = 1'b0;
	logic if_mode_i = 1'b0, manual_en_i = 1'b0, adv_power_save_i = 1'b0, aux_en_i = 1'b0;
	logic [6:0] dev_addr_i = SENSOR_ADDR;
	logic [1:0] rd_burst_i = 2'h1;
	logic [3:0] aux_offset_i = 4'h0;
	logic rd_addr_we_i = 1'b0, wr_addr_we_i = 1'b0, wr_data_we_i = 1'b0, data_rd_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic indirect_op_busy_o, drdy_o, nack_o, fifo_valid_o, scl_oe_o, sda_oe_o, sensor_low;
	logic scl_w, sda_w;
	logic [63:0] data_o, fifo_data_o;
	logic [3:0] fifo_len_o;
	int n_errors = 0, num_checks = 0;
	assign scl_w = !scl_oe_o;
	assign sda_w = !(sda_oe_o || sensor_low);
	initial begin
		forever #2.5 clk_i = !clk_i;
	end
	initial begin
		#1.3;
		forever #7.5 link_clk_i = !link_clk_i;
	end
	aux_sensor_i2c_master #(.PERIOD_CYC(32'h00004E20), .STEP_CYC(32'h000003E8))
		u_aux_sensor_i2c_master (
		.clk_i(clk_i), .resetn_i(resetn_i), .link_clk_i(link_clk_i),
		.if_mode_i(if_mode_i), .manual_en_i(manual_en_i),
		.adv_power_save_i(adv_power_save_i), .aux_en_i(aux_en_i),
		.dev_addr_i(dev_addr_i), .rd_burst_i(rd_burst_i), .aux_offset_i(aux_offset_i),
		.rd_addr_we_i(rd_addr_we_i), .wr_addr_we_i(wr_addr_we_i),
		.wr_data_we_i(wr_data_we_i), .wdata_i(wdata_i), .data_rd_i(data_rd_i),
		.indirect_op_busy_o(indirect_op_busy_o), .drdy_o(drdy_o), .nack_o(nack_o),
		.data_o(data_o), .fifo_valid_o(fifo_valid_o), .fifo_len_o(fifo_len_o),
		.fifo_data_o(fifo_data_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
		.sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o)
	);
	aux_sensor_model #(.ADDR(SENSOR_ADDR)) u_aux_sensor_model (
		.scl_i(scl_w), .sda_i(sda_w), .sda_low_o(sensor_low)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (n_errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One-cycle strobe: 0 read addr, 1 write addr, 2 write data, 3 data read
	task automatic strobe(input int k, input logic [7:0] v);
		@(negedge clk_i);
		wdata_i = v;
		{rd_addr_we_i, wr_addr_we_i, wr_data_we_i, data_rd_i} = 4'h8 >> k;
		@(negedge clk_i);
		{rd_addr_we_i, wr_addr_we_i, wr_data_we_i, data_rd_i} = 4'h0;
	endtask
	task automatic set_mode(input logic [3:0] m);
		@(negedge clk_i);
		{if_mode_i, manual_en_i, adv_power_save_i, aux_en_i} = m;
	endtask
	task automatic wait_until(input logic for_data);
		for (int n = 0; n < 60000; n++) begin
			@(negedge clk_i);
			if (for_data ? fifo_valid_o === 1'b1 : indirect_op_busy_o === 1'b0) begin
				return;
			end
		end
		n_errors++;
		$display("FAIL %0t wait ran out", $time);
		give_verdict();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge clk_i);
		`CHECK({indirect_op_busy_o, drdy_o, fifo_valid_o, scl_oe_o, sda_oe_o}, 5'h00, "reset")
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		// Data loaded before the address, since the address write launches
		for (int r = 0; r < 4; r++) begin
			set_mode(ROWS[r][4:1]);
			strobe(2, 8'hEF);
			strobe(1, 8'h03);
			repeat (2) @(negedge clk_i);
			`CHECK(indirect_op_busy_o, ROWS[r][0], "busy after address")
			wait_until(1'b0);
		end
		`CHECK(u_aux_sensor_model.mem[3], 8'hEF, "written byte")
		`CHECK(u_aux_sensor_model.n_data, 1, "one data byte")
		`CHECK(nack_o, 1'b0, "acked write")
		// Wrong target address must be refused by the sensor
		dev_addr_i = 7'h21;
		strobe(2, 8'h11);
		strobe(1, 8'h03);
		wait_until(1'b0);
		`CHECK(nack_o, 1'b1, "address refused")
		`CHECK(u_aux_sensor_model.mem[3], 8'hEF, "sensor untouched")
		dev_addr_i = SENSOR_ADDR;
		strobe(0, 8'h05);
		repeat (2) @(negedge clk_i);
		`CHECK(indirect_op_busy_o, 1'b1, "busy on read")
		wait_until(1'b0);
		`CHECK(data_o, {48'h0, 8'h06 ^ 8'h5A, 8'h05 ^ 8'h5A}, "read bytes")
		`CHECK(u_aux_sensor_model.n_sent, 2, "burst length")
		`CHECK(u_aux_sensor_model.last_nack, 1'b1, "last byte nacked")
		`CHECK(drdy_o, 1'b0, "no ready from setup")
		// Addresses reprogrammed with the interface off
		set_mode(4'h0);
		strobe(0, 8'h42);
		strobe(1, 8'h4B);
		strobe(2, 8'h01);
		rd_burst_i = 2'h0;
		aux_offset_i = 4'h4;
		set_mode(4'h9);
		// Offset 4 keeps the trigger write away until late in the period
		repeat (15000) @(negedge clk_i);
		`CHECK(u_aux_sensor_model.mem[8'h4B], 8'h4B ^ 8'h5A, "trigger too early")
		wait_until(1'b1);
		`CHECK(fifo_len_o, `AUX_BURST_LEN_0, "fifo length")
		`CHECK(fifo_data_o[7:0], 8'h42 ^ 8'h5A, "fifo byte")
		`CHECK(data_o[7:0], 8'h42 ^ 8'h5A, "data byte")
		`CHECK(drdy_o, 1'b1, "ready set")
		`CHECK(u_aux_sensor_model.mem[8'h4B], 8'h01, "trigger write")
		strobe(3, 8'h00);
		@(negedge clk_i);
		`CHECK(drdy_o, 1'b0, "ready cleared")
		set_mode(4'h0);
		give_verdict();
	end
endmodule

// >>> verif/aux_sensor_model.sv
// Behavioural auxiliary sensor: I2C target with a register map
`timescale 1ns/10ps
module aux_sensor_model #(
	parameter logic [6:0] ADDR = 7'h12
) (
	// Bus levels and pull-down drive
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_low_o
);
	logic [7:0] mem [0:255];
	logic [7:0] sh, ptr;
	logic act, rd, last_nack;
	int bitn, nbyte, n_data, n_sent;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
		{act, rd, last_nack, sda_low_o} = 4'h0;
	end
	// Sole target on the bus, so no arbitration is modelled
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			{act, rd, sda_low_o} = 3'h4;
			bitn = 0;
			nbyte = 0;
			n_data = 0;
			n_sent = 0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		if (act) begin
			if (bitn < 8) begin
				sh = {sh[6:0], sda_i};
			end else if (rd) begin
				last_nack = sda_i;
				act = !sda_i;
			end
			bitn++;
		end
	end
	// Released line floats high through the pull-up
	always @(negedge scl_i) begin
		if (act) begin
			if (bitn == 8 && !rd) begin
				sda_low_o = 1'b1;
				if (nbyte == 0) begin
					rd = sh[0];
					act = sh[7:1] == ADDR;
					sda_low_o = act;
				end else if (nbyte == 1) begin
					ptr = sh;
				end else begin
					mem[ptr] = sh;
					ptr++;
					n_data++;
				end
				nbyte++;
			end else if (bitn == 8) begin
				sda_low_o = 1'b0;
			end else if (bitn == 9) begin
				bitn = 0;
				sda_low_o = 1'b0;
				if (rd) begin
					sh = mem[ptr];
					ptr++;
					n_sent++;
					sda_low_o = !sh[7];
				end
			end else if (rd) begin
				sda_low_o = !sh[7];
			end
		end
	end
endmodule
